// file: inc/pit_pkg.sv
/*
  Constants and types for the preset interval timer core.
  Assumes a 10 MHz system clock and pins already synchronised by the core.
*/
package pit_pkg;

  localparam int unsigned CLK_HZ          = 10000000;
  localparam int unsigned PV_W            = 24;
  localparam logic [23:0] PV_ZERO         = 24'h000000;
  // Reset-to-output-off delay targets for the two input widths.
  localparam int unsigned RST_DLY_FAST_US = 1000;
  localparam int unsigned RST_DLY_SLOW_US = 20000;
  localparam int unsigned RST_FAST_CYC    = RST_DLY_FAST_US * (CLK_HZ / 1000000);
  localparam int unsigned RST_SLOW_CYC    = RST_DLY_SLOW_US * (CLK_HZ / 1000000);
  localparam int unsigned FILT_W          = 18;
  // Half-period of the blink of the time-unit indicators (the lamp toggles every BLINK_MS).
  localparam int unsigned BLINK_MS        = 500;
  localparam int unsigned BLINK_CYC       = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_W         = 23;

  // Output modes: signal on delay, power on delay, interval, cumulative, start-stop.
  typedef enum logic [2:0] {
    PIT_MODE_SIG_DLY  = 3'h0,
    PIT_MODE_PWR_DLY  = 3'h1,
    PIT_MODE_INTERVAL = 3'h2,
    PIT_MODE_CUMUL    = 3'h3,
    PIT_MODE_STSP     = 3'h4
  } pit_mode_e;

  typedef enum logic [1:0] {
    PIT_ST_IDLE = 2'h0,
    PIT_ST_RUN  = 2'h1,
    PIT_ST_DONE = 2'h3
  } pit_state_e;

endpackage

// file: verilog/pit_core.sv
/*
  Preset interval timer core: start, reset, gate inputs, control output,
  reset and time-unit indicators.
  Assumes pins come from outside the clock domain, and that tick is a one-cycle
  pulse from on-chip timebase logic, one per least unit of the chosen range.
*/
// Notes on behaviour
// RQ1: Start input begins timing in ordinary modes.
// RQ2: Power-on-delay modes: start inhibits timing.
// RQ3: Start-stop mode: start level runs timing.
// RQ4: Reset loads zero up, set value down.
// RQ5: While reset held: no counting, output off. The code does this only once the reset-width filter accepts reset.
// RQ6: Reset indicator lit exactly while reset active.
// RQ7: Gate freezes timing; reset still executes.
// RQ8: Output switches per mode at set value.
// RQ9: Fast variant: output off within reset window.
// RQ10: Minute/hour ranges blink unit indicators while timing.
// RQ11: Reset key acts like reset input.
// RQ12: Count direction up elapsed, down remaining.
// RQ13: One least unit per timebase tick.
`timescale 1ns/1ps
`default_nettype none
module pit_core
  import pit_pkg::*;
(
  // Clock and reset.
  input  wire logic            clock,
  input  wire logic            nrst,
  // Configuration and timebase.
  input  wire logic [2:0]      mode,
  input  wire logic            count_down,
  input  wire logic            coarse_range,
  input  wire logic            width_fast,
  input  wire logic [PV_W-1:0] set_value,
  input  wire logic            tick,
  // Pins and front-panel key.
  input  wire logic            start_pin,
  input  wire logic            reset_pin,
  input  wire logic            gate_pin,
  input  wire logic            reset_key,
  // Outputs.
  output logic [PV_W-1:0]      present_value,
  output logic                 ctrl_out,
  output logic                 reset_led,
  output logic                 unit_led
);

  // ==========================================================================
  // Input synchronisers and reset-width filter
  // ==========================================================================
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic       start_prev_r;
  logic [FILT_W-1:0] filt_r;
  logic       rst_q_r;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sync1_r      <= 4'h0;
      sync2_r      <= 4'h0;
      start_prev_r <= 1'b0;
    end else begin
      sync1_r      <= {reset_key, gate_pin, reset_pin, start_pin};
      sync2_r      <= sync1_r;
      start_prev_r <= sync2_r[0];
    end
  end

  wire start_s   = sync2_r[0];
  wire gate_s    = sync2_r[2];
  wire rst_raw   = sync2_r[1] | sync2_r[3]; // RQ11
  wire start_rise = start_s & ~start_prev_r;
  // Reset must stand for the selected minimum width before it is accepted;
  // this sets the reset-to-output-off delay of the fast variant.
  wire [FILT_W-1:0] filt_lim = width_fast ? FILT_W'(RST_FAST_CYC - 1) : FILT_W'(RST_SLOW_CYC - 1);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      filt_r  <= '0;
      rst_q_r <= 1'b0;
    end else if (!rst_raw) begin
      filt_r  <= '0;
      rst_q_r <= 1'b0;
    end else if (filt_r >= filt_lim) begin
      rst_q_r <= 1'b1; // RQ9
    end else begin
      filt_r  <= filt_r + FILT_W'(1);
    end
  end

  wire rst_act = rst_q_r;

  // ==========================================================================
  // Timing state
  // ==========================================================================
  pit_state_e state_r;
  pit_state_e state_nxt;
  logic [PV_W-1:0] pv_r;
  logic [PV_W-1:0] pv_nxt;
  logic            out_r;
  logic            out_nxt;

  wire pit_mode_e md      = pit_mode_e'(mode);
  wire is_pwr    = (md == PIT_MODE_PWR_DLY);
  wire is_stsp   = (md == PIT_MODE_STSP);
  wire [PV_W-1:0] pv_home = count_down ? set_value : PV_ZERO; // RQ4 RQ12
  wire [PV_W-1:0] pv_goal = count_down ? PV_ZERO : set_value;
  wire at_goal   = (pv_r == pv_goal);
  // Power-on delay runs from reset release unless start inhibits it.
  wire run_ok    = is_pwr ? ~start_s : (is_stsp ? start_s : 1'b1); // RQ1 RQ2 RQ3
  wire advance   = (state_r == PIT_ST_RUN) & run_ok & ~gate_s & tick & ~at_goal; // RQ7 RQ13
  wire begin_run = is_pwr | is_stsp ? 1'b1 : start_rise; // RQ1

  always_comb begin
    state_nxt = state_r;
    pv_nxt    = pv_r;
    out_nxt   = out_r;
    case (state_r)
      PIT_ST_IDLE: begin
        if (begin_run) begin
          state_nxt = PIT_ST_RUN;
          out_nxt   = (md == PIT_MODE_INTERVAL);
        end
      end
      PIT_ST_RUN: begin
        if (advance) begin
          pv_nxt = count_down ? pv_r - PV_W'(1) : pv_r + PV_W'(1);
        end
        if (at_goal) begin
          state_nxt = PIT_ST_DONE;
          out_nxt   = (md != PIT_MODE_INTERVAL); // RQ8
        end
      end
      PIT_ST_DONE: begin
        if (start_rise && md == PIT_MODE_SIG_DLY) begin
          // A fresh start restarts the delay from home.
          pv_nxt    = pv_home;
          out_nxt   = 1'b0;
          state_nxt = PIT_ST_RUN;
        end
      end
      default: state_nxt = PIT_ST_IDLE;
    endcase
    if (rst_act) begin
      state_nxt = PIT_ST_IDLE; // RQ5 RQ7
      pv_nxt    = pv_home;     // RQ4
      out_nxt   = 1'b0;        // RQ5
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_r <= PIT_ST_IDLE;
      pv_r    <= PV_ZERO;
      out_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pv_r    <= pv_nxt;
      out_r   <= out_nxt;
    end
  end

  // ==========================================================================
  // Indicators
  // ==========================================================================
  logic [BLINK_W-1:0] blink_cnt_r;
  logic               blink_r;
  logic               rled_r;
  wire timing = (state_r == PIT_ST_RUN) & run_ok & ~gate_s & ~rst_act;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      blink_cnt_r <= '0;
      blink_r     <= 1'b0;
      rled_r      <= 1'b0;
    end else begin
      rled_r <= rst_raw; // RQ6
      if (!timing) begin
        blink_cnt_r <= '0;
        blink_r     <= 1'b0;
      end else if (blink_cnt_r == BLINK_W'(BLINK_CYC - 1)) begin
        blink_cnt_r <= '0;
        blink_r     <= ~blink_r; // RQ10
      end else begin
        blink_cnt_r <= blink_cnt_r + BLINK_W'(1);
      end
    end
  end

  assign present_value = pv_r;
  assign ctrl_out      = out_r;
  assign reset_led     = rled_r;
  // Fine ranges keep the unit lamp steady; coarse ranges blink it.
  assign unit_led      = coarse_range ? ~blink_r : 1'b1;

  // ==========================================================================
  // Checks
  // ==========================================================================
  reset_out_off_a: assert property (@(posedge clock) disable iff (!nrst) // RQ5
    rst_act |=> !ctrl_out)
    else $error("control output on during reset");

  reset_load_a: assert property (@(posedge clock) disable iff (!nrst) // RQ4
    rst_act |=> (present_value == $past(pv_home)))
    else $error("reset did not load home value");

  reset_led_a: assert property (@(posedge clock) disable iff (!nrst) // RQ6
    rst_raw |=> reset_led)
    else $error("reset lamp dark during reset");

  gate_freeze_a: assert property (@(posedge clock) disable iff (!nrst) // RQ7
    (gate_s && !rst_act) |=> $stable(present_value))
    else $error("value moved while gated");

  pwr_inhibit_a: assert property (@(posedge clock) disable iff (!nrst) // RQ2
    (is_pwr && start_s && !rst_act) |=> $stable(present_value))
    else $error("power delay ran while inhibited");

  stsp_hold_a: assert property (@(posedge clock) disable iff (!nrst) // RQ3
    (is_stsp && !start_s && !rst_act) |=> $stable(present_value))
    else $error("start-stop ran while stopped");

  step_one_a: assert property (@(posedge clock) disable iff (!nrst) // RQ13
    (advance && !rst_act && !count_down) |=> (present_value == $past(pv_r) + PV_W'(1)))
    else $error("count step not one unit");

  goal_out_a: assert property (@(posedge clock) disable iff (!nrst) // RQ8
    (state_r == PIT_ST_RUN && at_goal && !rst_act && md == PIT_MODE_SIG_DLY) |=> ctrl_out)
    else $error("output not on at set value");

  fast_reset_a: assert property (@(posedge clock) disable iff (!nrst) // RQ9
    (width_fast && rst_raw && filt_r == filt_lim) |=> ##1 !ctrl_out)
    else $error("fast reset delay missed");

  sig_start_a: assert property (@(posedge clock) disable iff (!nrst) // RQ1
    (state_r == PIT_ST_IDLE && md == PIT_MODE_SIG_DLY && start_rise && !rst_act) |=> state_r == PIT_ST_RUN)
    else $error("start did not begin timing");

  led_dark_a: assert property (@(posedge clock) disable iff (!nrst) // RQ6
    !rst_raw |=> !reset_led)
    else $error("reset lamp lit without reset");

  unit_steady_a: assert property (@(posedge clock) disable iff (!nrst) // RQ10
    !timing |=> unit_led)
    else $error("unit lamp dark while not timing");

endmodule
`default_nettype wire

// file: sim/pit_partner.sv
/*
  Model of the switches and sensors wired to the timer's input pins.
  Assumes the bench states the wanted levels; contacts chatter on every change.
*/
`timescale 1ns/1ps
`default_nettype none
module pit_partner (
  // Wanted levels and the clock they change on.
  input  wire logic       clock,
  input  wire logic [3:0] want,
  // Pin levels seen by the timer.
  output logic [3:0]      pins
);
  logic [3:0]  last;
  logic [3:0]  chg;
  int unsigned bounce;
  initial begin
    pins   = 4'h0;
    last   = 4'h0;
    chg    = 4'h0;
    bounce = 0;
  end
  // =====================================================
  // Contact bounce
  // A real contact chatters, so only the changed pins glitch.
  // Pins move just after the falling edge, once the bench has set its wanted
  // levels for this cycle; reading them on the edge itself would race the bench.
  always @(negedge clock) begin
    #1;
    if (want !== last) begin
      chg    = want ^ last;
      last   = want;
      bounce = 3;
    end
    if (bounce != 0) begin
      bounce--;
      pins = last ^ (chg & 4'($urandom));
    end else begin
      pins = last;
    end
  end
endmodule
`default_nettype wire

// file: sim/testbench.sv
/*
  Self-checking bench for the timer core, with an integer model of the count.
  Assumes a 10 MHz clock and the filter counts fixed in the package.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  import pit_pkg::*;
  logic            clock = 0;
  logic            nrst = 0;
  logic [2:0]      mode = 3'h0;
  logic            count_down = 0;
  logic            width_fast = 1;
  logic            coarse_range = 0;
  logic [PV_W-1:0] set_value = 24'h000004;
  logic            tick = 0;
  logic [3:0]      want = 4'h0;
  logic [3:0]      pins;
  logic [PV_W-1:0] present_value;
  logic            ctrl_out;
  logic            reset_led;
  logic            unit_led;
  int              bad_count = 0;
  int              total_checks = 0;
  int              cycles = 0;
  int              exp_pv;
  int              sv;
  pit_partner sw_u (.clock(clock), .want(want), .pins(pins));
  pit_core dut_u (.clock(clock), .nrst(nrst), .mode(mode), .count_down(count_down),
    .coarse_range(coarse_range), .width_fast(width_fast), .set_value(set_value), .tick(tick),
    .start_pin(pins[0]), .reset_pin(pins[1]), .gate_pin(pins[2]), .reset_key(pins[3]),
    .present_value(present_value), .ctrl_out(ctrl_out), .reset_led(reset_led), .unit_led(unit_led));
  initial forever #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic ticks(input int n, input bit run);
    repeat (n) begin
      tick = 1;
      cyc(1);
      tick = 0;
      cyc(1);
      if (run) exp_pv += count_down ? -1 : 1;
      `CHK(present_value, 24'(exp_pv))
    end
  endtask
  task automatic init(input pit_mode_e m, input bit d, input bit f);
    nrst = 0;
    mode = m;
    count_down = d;
    width_fast = f;
    sv = 3 + $urandom % 6;
    set_value = 24'(sv);
    want = 4'h0;
    cyc(8);
    nrst = 1;
    cyc(4);
    exp_pv = 0;
  endtask
  task automatic restart();
    want[0] = 0;
    cyc(6);
    want[0] = 1;
    cyc(6);
  endtask
  // =====================================================
  // Reset by pin or key, held 1.2 ms
  task automatic hit_reset(input int b, input bit out_before);
    want[b] = 1;
    cyc(8);
    `CHK(reset_led, 1'b1)
    cyc(7892);
    `CHK(ctrl_out, out_before)
    cyc(4100);
    `CHK(ctrl_out, 1'b0)
    exp_pv = count_down ? sv : 0;
    `CHK(present_value, 24'(exp_pv))
    ticks(1, 0);
    want[b] = 0;
    cyc(8);
    `CHK(reset_led, 1'b0)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h673C0988));
    init(PIT_MODE_SIG_DLY, 0, 1);
    ticks(2, 0);
    want[0] = 1;
    cyc(6);
    ticks(sv - 1, 1);
    `CHK(unit_led, 1'b1)
    cyc(2);
    `CHK(ctrl_out, 1'b0)
    ticks(1, 1);
    cyc(2);
    `CHK(ctrl_out, 1'b1)
    hit_reset(1, 1);
    restart();
    ticks(sv, 1);
    cyc(2);
    hit_reset(3, 1);
    $display("test signal delay done");
    restart();
    ticks(1, 1);
    want[2] = 1;
    cyc(6);
    ticks(3, 0);
    hit_reset(1, 0);
    want[2] = 0;
    cyc(8);
    $display("test gate done");
    init(PIT_MODE_SIG_DLY, 1, 1);
    hit_reset(1, 0);
    want[0] = 1;
    cyc(6);
    ticks(sv, 1);
    cyc(2);
    `CHK(ctrl_out, 1'b1)
    $display("test down count done");
    init(PIT_MODE_PWR_DLY, 0, 1);
    want[0] = 1;
    cyc(6);
    ticks(2, 0);
    want[0] = 0;
    cyc(6);
    ticks(2, 1);
    init(PIT_MODE_STSP, 0, 1);
    coarse_range = 1;
    ticks(1, 0);
    `CHK(unit_led, 1'b1)
    want[0] = 1;
    cyc(6);
    ticks(2, 1);
    `CHK(unit_led, 1'b1)
    want[0] = 0;
    cyc(6);
    ticks(2, 0);
    `CHK(unit_led, 1'b1)
    coarse_range = 0;
    init(PIT_MODE_CUMUL, 0, 1);
    restart();
    ticks(2, 1);
    init(PIT_MODE_INTERVAL, 0, 1);
    restart();
    ticks(1, 1);
    cyc(2);
    `CHK(ctrl_out, 1'b1)
    ticks(sv - 1, 1);
    cyc(2);
    `CHK(ctrl_out, 1'b0)
    $display("test modes done");
    init(PIT_MODE_SIG_DLY, 0, 0);
    restart();
    ticks(sv, 1);
    cyc(2);
    want[1] = 1;
    cyc(10000);
    `CHK(reset_led, 1'b1)
    `CHK(ctrl_out, 1'b1)
    want[1] = 0;
    cyc(8);
    $display("test slow width done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
